// ---- design/rsq_pkg.sv ----
// Constants, register map and carrier types for the receive signal qualifiers
package rsq_pkg;

	// Register indices on the plain register port
	localparam logic [3:0] ADDR_PACKET_CONTROL_ONE     = 4'h0;
	localparam logic [3:0] ADDR_MODEM_CONFIG_TWO       = 4'h1;
	localparam logic [3:0] ADDR_GAIN_CONTROL_ZERO      = 4'h2;
	localparam logic [3:0] ADDR_GAIN_CONTROL_ONE       = 4'h3;
	localparam logic [3:0] ADDR_GAIN_CONTROL_TWO       = 4'h4;
	localparam logic [3:0] ADDR_RADIO_STATE_CONFIG_ONE = 4'h5;
	localparam logic [3:0] ADDR_PIN_SELECT             = 4'h6;
	localparam logic [3:0] ADDR_SIGNAL_STRENGTH        = 4'h8;
	localparam logic [3:0] ADDR_LINK_QUALITY           = 4'h9;
	localparam logic [3:0] ADDR_PACKET_STATUS          = 4'hA;
	localparam logic [3:0] ADDR_PREAMBLE_COUNT         = 4'hB;

	// Reset values of the writable registers
	localparam logic [7:0] RST_PACKET_CONTROL_ONE      = 8'h04;
	localparam logic [7:0] RST_MODEM_CONFIG_TWO        = 8'h02;
	localparam logic [7:0] RST_GAIN_CONTROL_ZERO       = 8'h01;
	localparam logic [7:0] RST_GAIN_CONTROL_ONE        = 8'h00;
	localparam logic [7:0] RST_GAIN_CONTROL_TWO        = 8'h03;
	localparam logic [7:0] RST_RADIO_STATE_CONFIG_ONE  = 8'h30;
	localparam logic [7:0] RST_PIN_SELECT              = 8'h21;

	// Field positions
	localparam int PQ_THR_LSB     = 5;
	localparam int APPEND_BIT     = 2;
	localparam int FILT_LEN_LSB   = 0;
	localparam int REL_STEP_LSB   = 4;
	localparam int ABS_OFF_LSB    = 0;
	localparam int GOAL_LSB       = 0;
	localparam int FRONT_LIM_LSB  = 3;
	localparam int DIG_LIM_LSB    = 6;
	localparam int CCA_SEL_LSB    = 4;
	localparam int PIN0_SEL_LSB   = 0;
	localparam int PIN1_SEL_LSB   = 4;
	localparam int ST_CS_BIT      = 6;
	localparam int ST_PQ_BIT      = 5;
	localparam int ST_CCA_BIT     = 4;
	localparam int ST_SYNC_BIT    = 3;

	// Preamble quality counter
	localparam logic [4:0] PQ_MAX      = 5'h1F;
	localparam logic [4:0] PQ_UP       = 5'h01;
	localparam logic [4:0] PQ_DOWN     = 5'h04;

	// Signal strength arithmetic, in half-dB unless named _db; ABS_OFF_OFF is a code of the offset in dB
	localparam logic [6:0] GOAL_BASE_DB = 7'h18;
	localparam logic [6:0] GOAL_STEP_DB = 7'h03;
	localparam logic signed [9:0] CS_HYST   = 10'sh002;
	localparam logic signed [9:0] REL_STEP1 = 10'sh00C;
	localparam logic signed [9:0] REL_STEP2 = 10'sh014;
	localparam logic signed [9:0] REL_STEP3 = 10'sh01C;
	localparam logic [3:0] ABS_OFF_OFF = 4'h8;

	// Update divider: 8 * 2^filter_length filter ticks per estimate
	localparam logic [10:0] RSSI_DIV_BASE = 11'h008;

	// Link quality window after sync
	localparam logic [6:0] LQI_SYMBOLS = 7'h40;

	// Output pin sources
	localparam logic [2:0] PIN_SRC_ZERO = 3'h0;
	localparam logic [2:0] PIN_SRC_PQ   = 3'h1;
	localparam logic [2:0] PIN_SRC_CS   = 3'h2;
	localparam logic [2:0] PIN_SRC_CCA  = 3'h3;
	localparam logic [2:0] PIN_SRC_SYNC = 3'h4;
	localparam logic [2:0] PIN_SRC_PKT  = 3'h5;

	// Clear channel modes, listed order from zero
	localparam logic [1:0] CCA_ALWAYS    = 2'h0;
	localparam logic [1:0] CCA_RSSI      = 2'h1;
	localparam logic [1:0] CCA_NO_PACKET = 2'h2;
	localparam logic [1:0] CCA_BOTH      = 2'h3;

	typedef struct packed {
		logic [7:0] packet_control_one;
		logic [7:0] modem_config_two;
		logic [7:0] gain_control_zero;
		logic [7:0] gain_control_one;
		logic [7:0] gain_control_two;
		logic [7:0] radio_state_config_one;
		logic [7:0] pin_select;
	} rsq_cfg_s;

	typedef struct packed {
		logic [7:0] strength;
		logic [7:0] quality;
	} rsq_status_s;

	typedef struct packed {
		logic [4:0] front_amp_gain_limit;
		logic [1:0] digital_amp_gain_limit;
	} rsq_gain_s;

endpackage

// ---- design/rsq_top.sv ----
// Receive signal qualifiers: preamble quality, strength, sense, CCA, LQI
`timescale 1ns/10ps

module rsq_top
	import rsq_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Receive chain
	input  wire logic              rx_enter,
	input  wire logic              in_rx,
	input  wire logic              bit_valid,
	input  wire logic              bit_data,
	input  wire logic              filt_tick,
	input  wire logic signed [7:0] level_half_db,
	input  wire logic [6:0]        gain_max_db,
	input  wire logic              sync_found,
	input  wire logic              pkt_active,
	input  wire logic              sym_valid,
	input  wire logic [6:0]        sym_metric,
	input  wire logic              pkt_end,
	input  wire logic              crc_ok,
	// Transmit strobes
	input  wire logic              transmit_strobe,
	input  wire logic              synth_on_for_transmit_strobe,
	output logic                   tx_enter,
	output logic                   synth_tx_enter,
	// Qualifiers
	output logic                   sync_search_allow,
	output logic                   term_qualifier,
	output logic                   carrier_sense,
	output logic                   clear_channel,
	output logic [1:0]             general_output_pin,
	output rsq_gain_s              gain_limits,
	// Appended status
	output logic                   status_valid,
	output rsq_status_s            status_bytes
);

	typedef struct packed {
		rsq_cfg_s           cfg;
		logic [7:0]         rdata;
		logic [4:0]         pq_cnt;
		logic               prev_bit;
		logic               have_prev;
		logic [10:0]        div_cnt;
		logic signed [7:0]  rssi;
		logic signed [7:0]  rssi_prev;
		logic signed [7:0]  rssi_sync;
		logic               frozen;
		logic               sync_seen;
		logic               abs_cs;
		logic               rel_cs;
		logic               lqi_run;
		logic [6:0]         lqi_cnt;
		logic [12:0]        lqi_sum;
		logic [6:0]         lqi;
		logic               tx_go;
		logic               fs_go;
		logic [1:0]         pins;
		logic               st_valid;
		rsq_status_s        st_bytes;
	} rsq_state_s;

	logic       rst_meta;
	logic       rst_sync_n;
	rsq_state_s st;
	rsq_state_s next_st;

	// Reset released through two flops; only the second is read
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	function automatic logic pin_pick(input logic [2:0] sel,
		input logic pq, input logic cs, input logic cca,
		input logic syn, input logic pkt);
		logic r;
		unique case (sel)
			PIN_SRC_PQ:   r = pq;
			PIN_SRC_CS:   r = cs;
			PIN_SRC_CCA:  r = cca;
			PIN_SRC_SYNC: r = syn;
			PIN_SRC_PKT:  r = pkt;
			default:      r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic signed [9:0] rel_step(input logic [1:0] code);
		logic signed [9:0] s;
		unique case (code)
			2'h1:    s = REL_STEP1;
			2'h2:    s = REL_STEP2;
			2'h3:    s = REL_STEP3;
			default: s = 10'sh000;
		endcase
		return s;
	endfunction

	// Configuration fields
	logic [2:0]        pq_code;
	logic              append_en;
	logic [2:0]        sync_mode;
	logic [1:0]        filt_len;
	logic [1:0]        rel_code;
	logic [3:0]        abs_off;
	logic [2:0]        goal_code;
	logic [1:0]        cca_sel;
	logic [10:0]       div_last;
	logic [6:0]        goal_db;
	logic signed [9:0] thr_db;
	logic signed [9:0] thr_half;
	logic signed [9:0] cur_ext;
	logic signed [9:0] prev_ext;
	logic signed [9:0] diff;
	logic signed [9:0] step;
	logic              pq_reached;
	logic              cs_now;
	logic              cca_now;
	logic              rssi_upd;
	logic [4:0]        pq_thr;

	always_comb begin
		pq_code   = st.cfg.packet_control_one[PQ_THR_LSB +: 3];
		append_en = st.cfg.packet_control_one[APPEND_BIT];
		sync_mode = st.cfg.modem_config_two[2:0];
		filt_len  = st.cfg.gain_control_zero[FILT_LEN_LSB +: 2];
		rel_code  = st.cfg.gain_control_one[REL_STEP_LSB +: 2];
		abs_off   = st.cfg.gain_control_one[ABS_OFF_LSB +: 4];
		goal_code = st.cfg.gain_control_two[GOAL_LSB +: 3];
		cca_sel   = st.cfg.radio_state_config_one[CCA_SEL_LSB +: 2];
		div_last  = (RSSI_DIV_BASE << filt_len) - 11'h001;
		goal_db   = GOAL_BASE_DB + GOAL_STEP_DB * {4'h0, goal_code};
		// Offset code minus eight is outside the range and disables it
		thr_db    = $signed({3'b000, goal_db})
		          + $signed({{6{abs_off[3]}}, abs_off})
		          - $signed({3'b000, gain_max_db});
		thr_half  = {thr_db[8:0], 1'b0};
		cur_ext   = {{2{level_half_db[7]}}, level_half_db};
		prev_ext  = {{2{st.rssi_prev[7]}}, st.rssi_prev};
		diff      = cur_ext - prev_ext;
		step      = rel_step(rel_code);
		pq_thr    = {pq_code, 2'b00};
		pq_reached = (pq_code == 3'h0)
		          || (st.pq_cnt >= pq_thr);
		cs_now    = st.abs_cs || st.rel_cs;
		unique case (cca_sel)
			CCA_ALWAYS:    cca_now = 1'b1;
			CCA_RSSI:      cca_now = !cs_now;
			CCA_NO_PACKET: cca_now = !pkt_active;
			CCA_BOTH:      cca_now = !cs_now && !pkt_active;
		endcase
		rssi_upd  = filt_tick && (st.div_cnt == div_last);
	end

	always_comb begin
		next_st = st;
		next_st.tx_go    = 1'b0;
		next_st.fs_go    = 1'b0;
		next_st.st_valid = 1'b0;

		// Register writes; status registers ignore writes
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_PACKET_CONTROL_ONE:
					next_st.cfg.packet_control_one = reg_wdata;
				ADDR_MODEM_CONFIG_TWO:
					next_st.cfg.modem_config_two = reg_wdata;
				ADDR_GAIN_CONTROL_ZERO:
					next_st.cfg.gain_control_zero = reg_wdata;
				ADDR_GAIN_CONTROL_ONE:
					next_st.cfg.gain_control_one = reg_wdata;
				ADDR_GAIN_CONTROL_TWO:
					next_st.cfg.gain_control_two = reg_wdata;
				ADDR_RADIO_STATE_CONFIG_ONE:
					next_st.cfg.radio_state_config_one = reg_wdata;
				ADDR_PIN_SELECT:
					next_st.cfg.pin_select = reg_wdata;
				default: ;
			endcase
		end
		// Read data lasts one cycle; zero between answers keeps it OR-able
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_PACKET_CONTROL_ONE:
					next_st.rdata = st.cfg.packet_control_one;
				ADDR_MODEM_CONFIG_TWO:
					next_st.rdata = st.cfg.modem_config_two;
				ADDR_GAIN_CONTROL_ZERO:
					next_st.rdata = st.cfg.gain_control_zero;
				ADDR_GAIN_CONTROL_ONE:
					next_st.rdata = st.cfg.gain_control_one;
				ADDR_GAIN_CONTROL_TWO:
					next_st.rdata = st.cfg.gain_control_two;
				ADDR_RADIO_STATE_CONFIG_ONE:
					next_st.rdata = st.cfg.radio_state_config_one;
				ADDR_PIN_SELECT:
					next_st.rdata = st.cfg.pin_select;
				ADDR_SIGNAL_STRENGTH:
					next_st.rdata = st.rssi;
				ADDR_LINK_QUALITY:
					next_st.rdata = {1'b0, st.lqi};
				ADDR_PACKET_STATUS: begin
					next_st.rdata[ST_CS_BIT]   = cs_now;
					next_st.rdata[ST_PQ_BIT]   = pq_reached;
					next_st.rdata[ST_CCA_BIT]  = cca_now;
					next_st.rdata[ST_SYNC_BIT] = st.sync_seen;
				end
				ADDR_PREAMBLE_COUNT:
					next_st.rdata = {3'b000, st.pq_cnt};
				default: ;
			endcase
		end

		// Preamble quality estimator
		if (rx_enter) begin
			next_st.pq_cnt    = 5'h00;
			next_st.have_prev = 1'b0;
		end else if (bit_valid) begin
			next_st.prev_bit  = bit_data;
			next_st.have_prev = 1'b1;
			if (st.have_prev && (bit_data != st.prev_bit)) begin
				if (st.pq_cnt != PQ_MAX)
					next_st.pq_cnt = st.pq_cnt + PQ_UP;
			end else if (st.have_prev) begin
				if (st.pq_cnt < PQ_DOWN)
					next_st.pq_cnt = 5'h00;
				else
					next_st.pq_cnt = st.pq_cnt - PQ_DOWN;
			end
		end

		// Strength estimate and carrier sense on the update divider
		// Divider runs outside receive too; entry realigns it to a window
		if (filt_tick)
			next_st.div_cnt = rssi_upd ? 11'h000 : st.div_cnt + 11'h001;
		if (rx_enter) begin
			next_st.frozen    = 1'b0;
			next_st.sync_seen = 1'b0;
			next_st.div_cnt   = 11'h000;
			next_st.abs_cs    = 1'b0;
			next_st.rel_cs    = 1'b0;
		end else if (in_rx && rssi_upd) begin
			next_st.rssi_prev = level_half_db;
			if (!st.frozen)
				next_st.rssi = level_half_db;
			if (abs_off == ABS_OFF_OFF)
				next_st.abs_cs = 1'b0;
			else if (cur_ext > thr_half + CS_HYST)
				next_st.abs_cs = 1'b1;
			else if (cur_ext < thr_half - CS_HYST)
				next_st.abs_cs = 1'b0;
			if (step == 10'sh000)
				next_st.rel_cs = 1'b0;
			else if (diff >= step)
				next_st.rel_cs = 1'b1;
			else if (-diff >= step)
				next_st.rel_cs = 1'b0;
		end
		// Capture skipped on the entry cycle so a stale sync cannot refreeze
		if (sync_found && !rx_enter) begin
			next_st.sync_seen = 1'b1;
			next_st.rssi_sync = st.rssi;
			// Freeze only when a sync word is actually searched for
			if (sync_mode[1:0] != 2'b00)
				next_st.frozen = 1'b1;
		end

		// Link quality over the symbols after sync
		// Sum of 64 seven-bit metrics fits 13 bits; top seven give the mean
		if (sync_found) begin
			next_st.lqi_run = 1'b1;
			next_st.lqi_cnt = 7'h00;
			next_st.lqi_sum = 13'h0000;
		end else if (st.lqi_run && sym_valid) begin
			next_st.lqi_sum = st.lqi_sum + {6'h00, sym_metric};
			next_st.lqi_cnt = st.lqi_cnt + 7'h01;
			if (st.lqi_cnt == LQI_SYMBOLS - 7'h01) begin
				next_st.lqi_run = 1'b0;
				next_st.lqi = next_st.lqi_sum[12:6];
			end
		end

		// Appended status bytes at packet end
		if (pkt_end && append_en) begin
			next_st.st_valid = 1'b1;
			next_st.st_bytes.strength = st.rssi_sync;
			next_st.st_bytes.quality  = {crc_ok, st.lqi};
		end

		// Transmit if clear
		next_st.tx_go = transmit_strobe && (!in_rx || cca_now);
		next_st.fs_go = synth_on_for_transmit_strobe
		             && (!in_rx || cca_now);

		next_st.pins[0] = pin_pick(st.cfg.pin_select[PIN0_SEL_LSB +: 3],
			pq_reached, cs_now, cca_now, st.sync_seen, pkt_active);
		next_st.pins[1] = pin_pick(st.cfg.pin_select[PIN1_SEL_LSB +: 3],
			pq_reached, cs_now, cca_now, st.sync_seen, pkt_active);
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st     <= '0;
			st.cfg <= '{RST_PACKET_CONTROL_ONE, RST_MODEM_CONFIG_TWO,
				RST_GAIN_CONTROL_ZERO, RST_GAIN_CONTROL_ONE,
				RST_GAIN_CONTROL_TWO, RST_RADIO_STATE_CONFIG_ONE,
				RST_PIN_SELECT};
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		reg_rdata      = st.rdata;
		tx_enter       = st.tx_go;
		synth_tx_enter = st.fs_go;
		// Sense gate only for modes with the top bit set
		sync_search_allow = pq_reached
		                 && (!sync_mode[2] || cs_now);
		term_qualifier = pq_reached;
		carrier_sense  = cs_now;
		clear_channel  = cca_now;
		general_output_pin = st.pins;
		gain_limits.front_amp_gain_limit =
			{2'b00, st.cfg.gain_control_two[FRONT_LIM_LSB +: 3]};
		gain_limits.digital_amp_gain_limit =
			st.cfg.gain_control_two[DIG_LIM_LSB +: 2];
		status_valid   = st.st_valid;
		status_bytes   = st.st_bytes;
	end

endmodule

// ---- dv/rsq_assertions.sv ----
// Port checker for the receive signal qualifiers
`timescale 1ns/10ps
module rsq_assertions
	import rsq_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        arst_n,
	// Register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// Receive chain
	input wire logic        rx_enter,
	input wire logic        in_rx,
	input wire logic        filt_tick,
	input wire logic        pkt_end,
	// Strobes and qualifiers
	input wire logic        transmit_strobe,
	input wire logic        synth_on_for_transmit_strobe,
	input wire logic        tx_enter,
	input wire logic        synth_tx_enter,
	input wire logic        carrier_sense,
	input wire logic        clear_channel,
	input wire rsq_gain_s   gain_limits,
	// Appended status
	input wire logic        status_valid,
	input wire rsq_status_s status_bytes
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	AST_TX_GRANT: assert property (
		transmit_strobe && (!in_rx || clear_channel) |=> tx_enter)
		else $error("granted transmit strobe gave no entry pulse");
	AST_TX_REFUSE: assert property (
		transmit_strobe && in_rx && !clear_channel |=> !tx_enter)
		else $error("transmit entered on a busy channel");
	AST_SYN_GRANT: assert property (
		synth_on_for_transmit_strobe && (!in_rx || clear_channel)
		|=> synth_tx_enter)
		else $error("granted synth strobe gave no entry pulse");
	AST_TX_CAUSE: assert property (
		tx_enter |-> $past(transmit_strobe))
		else $error("transmit entry without a strobe");
	AST_STATUS_CAUSE: assert property (
		status_valid |-> $past(pkt_end))
		else $error("status bytes without packet end");
	AST_STATUS_HOLD: assert property (
		!status_valid |-> $stable(status_bytes))
		else $error("status bytes moved without a packet end");
	AST_CS_CAUSE: assert property (
		$changed(carrier_sense) |-> $past(filt_tick || rx_enter || reg_wr))
		else $error("carrier sense moved without an update");
	AST_GAIN_HOLD: assert property (
		!reg_wr |=> $stable(gain_limits))
		else $error("gain limits moved without a write");
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read answer");
endmodule

bind rsq_top rsq_assertions u_rsq_assertions (
	.clk_sys, .arst_n, .reg_wr, .reg_rd, .reg_rdata, .rx_enter, .in_rx,
	.filt_tick, .pkt_end, .transmit_strobe, .synth_on_for_transmit_strobe,
	.tx_enter, .synth_tx_enter, .carrier_sense, .clear_channel,
	.gain_limits, .status_valid, .status_bytes
);

// ---- dv/rsq_rx_model.sv ----
// Receive chain stand-in: demodulated bits, filter ticks, symbols
`timescale 1ns/10ps
module rsq_rx_model (
	// Clock
	input  wire logic clk_sys,
	// Receive chain outputs
	output logic       bit_valid,
	output logic       bit_data,
	output logic       filt_tick,
	output logic       sym_valid,
	output logic [6:0] sym_metric
);
	logic last;

	initial begin
		{bit_valid, bit_data, filt_tick, sym_valid, last} = 5'h00;
		sym_metric = 7'h00;
	end

	// Idle data lines show the inverse so stale values never look valid
	task automatic send_bits(input int n, input logic alt);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			last = alt ? !last : last;
			bit_valid <= 1'b1;
			bit_data  <= last;
			@(posedge clk_sys);
			bit_valid <= 1'b0;
			bit_data  <= !last;
		end
		#1;
	endtask

	task automatic ticks(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			filt_tick <= 1'b1;
			@(posedge clk_sys);
			filt_tick <= 1'b0;
		end
		#1;
	endtask

	task automatic send_syms(input int n, input logic [6:0] m);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			sym_valid  <= 1'b1;
			sym_metric <= m;
			@(posedge clk_sys);
			sym_valid  <= 1'b0;
			sym_metric <= ~m;
		end
		#1;
	endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the receive signal qualifiers
`timescale 1ns/10ps
module tb
	import rsq_pkg::*;
;
	localparam logic [7:0] RST_TAB [7] = '{RST_PACKET_CONTROL_ONE,
		RST_MODEM_CONFIG_TWO, RST_GAIN_CONTROL_ZERO, RST_GAIN_CONTROL_ONE,
		RST_GAIN_CONTROL_TWO, RST_RADIO_STATE_CONFIG_ONE, RST_PIN_SELECT};
	logic        clk_sys, arst_n, reg_wr, reg_rd, rx_enter, in_rx;
	logic        bit_valid, bit_data, filt_tick, sync_found, pkt_active;
	logic        sym_valid, pkt_end, crc_ok, transmit_strobe, e;
	logic        synth_on_for_transmit_strobe, tx_enter, synth_tx_enter;
	logic        sync_search_allow, term_qualifier, carrier_sense;
	logic        clear_channel, status_valid;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d, s;
	logic [7:0]  level_half_db;
	logic [6:0]  gain_max_db, sym_metric;
	logic [1:0]  general_output_pin;
	rsq_gain_s   gain_limits;
	rsq_status_s status_bytes;
	int          n_fail, check_count, cyc;

	rsq_top u_rsq_top (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rx_enter, .in_rx, .bit_valid, .bit_data,
		.filt_tick, .level_half_db, .gain_max_db, .sync_found, .pkt_active,
		.sym_valid, .sym_metric, .pkt_end, .crc_ok, .transmit_strobe,
		.synth_on_for_transmit_strobe, .tx_enter, .synth_tx_enter,
		.sync_search_allow, .term_qualifier, .carrier_sense, .clear_channel,
		.general_output_pin, .gain_limits, .status_valid, .status_bytes);
	rsq_rx_model u_rsq_rx_model (.clk_sys, .bit_valid, .bit_data,
		.filt_tick, .sym_valid, .sym_metric);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bchk(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		rd(a);
		chk({8'h00, d}, {8'h00, exp});
	endtask
	// Codes: 0 receive entry, 1 sync, 2 packet end, 3 and 4 strobes
	task automatic pulse(input int k);
		@(posedge clk_sys);
		case (k)
			0: rx_enter <= 1'b1;
			1: sync_found <= 1'b1;
			2: pkt_end <= 1'b1;
			3: transmit_strobe <= 1'b1;
			default: synth_on_for_transmit_strobe <= 1'b1;
		endcase
		@(posedge clk_sys);
		{rx_enter, sync_found, pkt_end} <= 3'h0;
		{transmit_strobe, synth_on_for_transmit_strobe} <= 2'h0;
		#1;
	endtask
	// Groups of 16 ticks keep the filter-length-1 divider aligned
	task automatic upd(input logic [7:0] l, input int n);
		level_half_db <= l;
		u_rsq_rx_model.ticks(n);
	endtask

	initial begin
		{arst_n, reg_wr, reg_rd, rx_enter, in_rx, sync_found} = 6'h00;
		{pkt_active, pkt_end, transmit_strobe} = 3'h0;
		synth_on_for_transmit_strobe = 1'b0;
		{reg_addr, reg_wdata, level_half_db} = 20'h00000;
		gain_max_db = 7'h28;
		crc_ok = 1'b1;
		n_fail      = 0;
		check_count = 0;
		cyc         = 0;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 7; i++)
			rchk(i[3:0], RST_TAB[i]);
		rchk(4'h7, 8'h00);
		rchk(4'hF, 8'h00);
		wr(ADDR_PREAMBLE_COUNT, 8'h1F);
		rchk(ADDR_PREAMBLE_COUNT, 8'h00);
		wr(ADDR_GAIN_CONTROL_TWO, 8'hE5);
		rchk(ADDR_GAIN_CONTROL_TWO, 8'hE5);
		chk({9'h000, gain_limits}, 16'h0013);
		wr(ADDR_GAIN_CONTROL_TWO, 8'h03);
		in_rx <= 1'b1;
		pulse(0);
		u_rsq_rx_model.send_bits(40, 1'b1);
		rchk(ADDR_PREAMBLE_COUNT, 8'h1F);
		u_rsq_rx_model.send_bits(3, 1'b0);
		rchk(ADDR_PREAMBLE_COUNT, 8'h13);
		u_rsq_rx_model.send_bits(5, 1'b0);
		rchk(ADDR_PREAMBLE_COUNT, 8'h00);
		u_rsq_rx_model.send_bits(4, 1'b1);
		pulse(0);
		rchk(ADDR_PREAMBLE_COUNT, 8'h00);
		wr(ADDR_PACKET_CONTROL_ONE, 8'h44);
		u_rsq_rx_model.send_bits(8, 1'b1);
		bchk(term_qualifier, 1'b0);
		u_rsq_rx_model.send_bits(1, 1'b1);
		bchk(term_qualifier, 1'b1);
		rd(ADDR_PACKET_STATUS);
		bchk(d[ST_PQ_BIT], 1'b1);
		bchk(general_output_pin[0], 1'b1);
		wr(ADDR_PACKET_CONTROL_ONE, 8'h04);
		pulse(0);
		bchk(term_qualifier, 1'b1);
		upd(8'h20, 16);
		rchk(ADDR_SIGNAL_STRENGTH, 8'h20);
		upd(8'hD0, 15);
		rchk(ADDR_SIGNAL_STRENGTH, 8'h20);
		upd(8'hD0, 1);
		rchk(ADDR_SIGNAL_STRENGTH, 8'hD0);
		pulse(1);
		upd(8'h40, 16);
		rchk(ADDR_SIGNAL_STRENGTH, 8'hD0);
		pulse(0);
		upd(8'h40, 16);
		rchk(ADDR_SIGNAL_STRENGTH, 8'h40);
		pulse(0);
		upd(8'hF3, 16);
		bchk(carrier_sense, 1'b0);
		upd(8'h00, 16);
		bchk(carrier_sense, 1'b1);
		rd(ADDR_PACKET_STATUS);
		bchk(d[ST_CS_BIT], 1'b1);
		bchk(general_output_pin[1], 1'b1);
		upd(8'hF3, 16);
		bchk(carrier_sense, 1'b1);
		upd(8'hEC, 16);
		bchk(carrier_sense, 1'b0);
		wr(ADDR_GAIN_CONTROL_ONE, 8'h07);
		upd(8'h00, 16);
		bchk(carrier_sense, 1'b0);
		upd(8'h03, 16);
		bchk(carrier_sense, 1'b1);
		for (int k = 1; k < 4; k++) begin
			s = 8'(4 + 8 * k);
			wr(ADDR_GAIN_CONTROL_ONE, {2'b00, k[1:0], 4'h8});
			pulse(0);
			upd(8'h9C, 16);
			upd(8'h9C + s - 8'h01, 16);
			bchk(carrier_sense, 1'b0);
			upd(8'h9C + s + s - 8'h01, 16);
			bchk(carrier_sense, 1'b1);
			upd(8'h9C + s - 8'h01, 16);
			bchk(carrier_sense, 1'b0);
		end
		wr(ADDR_GAIN_CONTROL_ONE, 8'h00);
		wr(ADDR_PIN_SELECT, 8'h31);
		for (int c = 0; c < 2; c++) begin
			upd(c ? 8'hEC : 8'h00, 16);
			pkt_active <= c[0];
			wr(ADDR_MODEM_CONFIG_TWO, 8'h06);
			bchk(sync_search_allow, !c[0]);
			wr(ADDR_MODEM_CONFIG_TWO, 8'h02);
			bchk(sync_search_allow, 1'b1);
			for (int m = 0; m < 4; m++) begin
				wr(ADDR_RADIO_STATE_CONFIG_ONE, {2'b00, m[1:0], 4'h0});
				e = m == 0 || (m == 1 && c == 1) || (m == 2 && c == 0);
				bchk(clear_channel, e);
				step;
				bchk(general_output_pin[1], e);
				pulse(3);
				bchk(tx_enter, e);
				pulse(4);
				bchk(synth_tx_enter, e);
			end
		end
		in_rx <= 1'b0;
		pulse(3);
		bchk(tx_enter, 1'b1);
		{in_rx, pkt_active} <= 2'b11;
		pulse(0);
		upd(8'h22, 16);
		pulse(1);
		wr(ADDR_PIN_SELECT, 8'h54);
		step;
		chk({14'h0000, general_output_pin}, 16'h0003);
		rd(ADDR_PACKET_STATUS);
		chk({8'h00, d}, 16'h0068);
		wr(ADDR_PIN_SELECT, 8'h00);
		step;
		chk({14'h0000, general_output_pin}, 16'h0000);
		u_rsq_rx_model.send_syms(63, 7'h50);
		rchk(ADDR_LINK_QUALITY, 8'h00);
		u_rsq_rx_model.send_syms(1, 7'h50);
		rchk(ADDR_LINK_QUALITY, 8'h50);
		pulse(2);
		bchk(status_valid, 1'b1);
		chk(status_bytes, 16'h22D0);
		step;
		bchk(status_valid, 1'b0);
		wr(ADDR_PACKET_CONTROL_ONE, 8'h00);
		pulse(2);
		bchk(status_valid, 1'b0);
		wr(ADDR_MODEM_CONFIG_TWO, 8'h00);
		pulse(0);
		pulse(1);
		upd(8'h11, 16);
		rchk(ADDR_SIGNAL_STRENGTH, 8'h11);
		wr(ADDR_GAIN_CONTROL_ZERO, 8'h00);
		upd(8'h12, 7);
		rchk(ADDR_SIGNAL_STRENGTH, 8'h11);
		upd(8'h12, 1);
		rchk(ADDR_SIGNAL_STRENGTH, 8'h12);
		arst_n <= 1'b0;
		step;
		arst_n <= 1'b1;
		repeat (3) step;
		rchk(ADDR_PACKET_CONTROL_ONE, RST_PACKET_CONTROL_ONE);
		rchk(ADDR_SIGNAL_STRENGTH, 8'h00);
		end_sim;
	end
endmodule
